// *** dtdp_carrier.sv ***
module dtdp_carrier (
  input wire logic mclk_i,
  input wire logic go_i,
  input wire logic [7:0] len_i,
  output logic carrier_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] left_r = 8'h00;
  // One burst per request; idle low between bursts
  always_ff @(posedge mclk_i) begin
    if (go_i) left_r <= len_i;
    else if (left_r != 8'h00) left_r <= left_r - 8'h01;
  end
  assign carrier_o = (left_r != 8'h00);
endmodule

// *** dtdp_pkg.sv ***
package dtdp_pkg;
  // Register indices; index n sits at byte address n
  localparam logic [3:0] A_SHORT_CTRL = 4'h0;
  localparam logic [3:0] A_MODE_CTRL = 4'h1;
  localparam logic [3:0] A_LONG_CTRL = 4'h2;
  localparam logic [3:0] A_SRL_LOW = 4'h4;
  localparam logic [3:0] A_SRL_HIGH = 4'h5;
  localparam logic [3:0] A_LRL_LOW = 4'h6;
  localparam logic [3:0] A_LRL_HIGH = 4'h7;
  localparam logic [3:0] A_LCAP_LOW = 4'h8;
  localparam logic [3:0] A_LCAP_HIGH = 4'h9;
  localparam logic [3:0] A_SCAP_LOW = 4'ha;
  localparam logic [3:0] A_SCAP_HIGH = 4'hb;
  // Control bit positions
  localparam int B_EN = 7;
  localparam int B_SM = 6;
  localparam int B_TO = 5;
  localparam int B_CKH = 4;
  localparam int B_CKL = 3;
  localparam int B_CAPIE = 2;
  localparam int B_TOIE = 1;
  localparam int B_OUTEN = 0;
  // Mode control positions
  localparam int M_XMIT = 7;
  localparam int M_EDGEH = 5;
  localparam int M_EDGEL = 4;
  localparam int M_PPH = 3;
  localparam int M_PPL = 2;
  localparam int M_INIT_S = 1;
  localparam int M_INIT_L = 0;
  localparam int M_EDR = 1;
  localparam int M_EDF = 0;
  localparam logic [1:0] PP_OFF = 2'h0;
  localparam logic [1:0] PP_ON = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h80;
  localparam logic [7:0] ALL_ONES8 = 8'hff;
  localparam logic [15:0] ALL_ONES16 = 16'hffff;
  localparam logic [2:0] PRE_MAX = 3'h7;
  typedef enum logic [1:0] {DTDP_IDLE = 2'b00, DTDP_ARMED = 2'b01,
                            DTDP_COUNT = 2'b11} dtdp_dm_t;
endpackage

// *** dtdp_timer.sv ***
// Contract
// R1: Long timer runs only while its enable bit is one.
// R2: Transmit: select zero reloads at terminal count, one halts there.
// R3: Short timer wrap from zero to FFh is no timeout.
// R4: Software stops a timer and clears its flags in separate writes.
// R5: Software loads both short reload registers with FFh for demodulation.
// R6: Demodulation: short timer starts counting on first selected edge.
// R7: Later edge stores complemented count: rising to low, falling to high capture.
// R8: Initial long count one is forbidden; zero wraps to FFFFh, no timeout.
// R9: Software avoids writing hold registers during counter reload.
// R10: First selected long edge captures both bytes, reloads and starts.
// R11: Select zero: each later edge captures complement, reloads FFFFh, restarts.
// R12: Long capture sets edge status bit and interrupts when enabled.
// R13: Select one: long timer ignores later edges, keeps counting.
// R14: Select one: short timeout captures long count, interrupts, no reload.
// R15: Writing select zero then one re-arms capture on next edge.
// R16: Demodulation long zero continues from FFFFh, sets timeout, interrupts.
// R17: Software uses ping-pong only in transmit with both single-pass.
// R18: Ping-pong short start sets initial level, loads hold by level.
// R19: Short terminal count hands to long timer; long end restarts short.
// R20: Each timer may interrupt; writing 00 to ping-pong field stops alternation.
// R21: Software disables timers and clears flags before enabling ping-pong.
// R22: Enabled timers decrement once per selected prescaled clock tick.
//
// Implementation choices: the plain strobed port and the register offsets.
module dtdp_timer
  import dtdp_pkg::*;
(
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic demod_in_i,
  output logic [7:0] rdata_o,
  output logic short_timer_output_o,
  output logic long_timer_output_o,
  output logic short_irq_o,
  output logic long_irq_o
);
  logic [7:0] sctl_r;
  logic [7:0] mctl_r;
  logic [7:0] lctl_r;
  logic [7:0] srl_lo_r;
  logic [7:0] srl_hi_r;
  logic [7:0] lrl_lo_r;
  logic [7:0] lrl_hi_r;
  logic [7:0] scap_lo_r;
  logic [7:0] scap_hi_r;
  logic [7:0] lcap_lo_r;
  logic [7:0] lcap_hi_r;
  logic [7:0] scnt_r;
  logic [15:0] lcnt_r;
  logic [2:0] pre_r;
  logic sync1_r;
  logic sync2_r;
  logic sync3_r;
  logic sout_r;
  logic lout_r;
  logic sirq_r;
  logic lirq_r;
  logic [7:0] rdata_r;
  dtdp_dm_t sdm_r;
  dtdp_dm_t ldm_r;

  function automatic logic tick_sel(input logic [1:0] sel, input logic [2:0] pre);
    unique case (sel)
      2'h0: tick_sel = 1'b1;
      2'h1: tick_sel = pre[0];
      2'h2: tick_sel = &pre[1:0];
      2'h3: tick_sel = (pre == PRE_MAX);
    endcase
  endfunction

  wire wr_sctl = wr_i && (addr_i == A_SHORT_CTRL);
  wire wr_mctl = wr_i && (addr_i == A_MODE_CTRL);
  wire wr_lctl = wr_i && (addr_i == A_LONG_CTRL);
  wire wr_srl_lo = wr_i && (addr_i == A_SRL_LOW);
  wire wr_srl_hi = wr_i && (addr_i == A_SRL_HIGH);
  wire wr_lrl_lo = wr_i && (addr_i == A_LRL_LOW);
  wire wr_lrl_hi = wr_i && (addr_i == A_LRL_HIGH);
  wire xmit = mctl_r[M_XMIT];
  wire pingpong = xmit && (mctl_r[M_PPH:M_PPL] == PP_ON);
  wire [1:0] edge_sel = mctl_r[M_EDGEH:M_EDGEL];
  // Sync stage one feeds only stage two
  wire rise = sync2_r && !sync3_r;
  wire fall = !sync2_r && sync3_r;
  wire edge_hit = (edge_sel == EDGE_BOTH) ? (rise || fall) :
                  (edge_sel == EDGE_FALL) ? fall : rise;
  wire s_en = sctl_r[B_EN];
  wire l_en = lctl_r[B_EN];
  wire s_tick = tick_sel(sctl_r[B_CKH:B_CKL], pre_r); // R22
  wire l_tick = tick_sel(lctl_r[B_CKH:B_CKL], pre_r); // R22
  wire s_run = s_en && (xmit || sdm_r == DTDP_COUNT);
  wire l_run = l_en && (xmit || ldm_r == DTDP_COUNT); // R1
  // Terminal count is reaching one then stepping; zero wraps, and long zero also times out in demodulation
  wire s_term = s_run && s_tick && (scnt_r == 8'h01); // R3
  wire l_term = l_run && l_tick && (lcnt_r == 16'h0001);
  wire l_zero = l_run && l_tick && (lcnt_r == 16'h0000); // R8
  wire s_next_out = ~sout_r;
  wire [7:0] s_hold = s_next_out ? srl_hi_r : srl_lo_r;
  wire [15:0] l_hold = {lrl_hi_r, lrl_lo_r};
  wire l_ign = lctl_r[B_SM];
  wire l_edge_cap = !xmit && l_en && edge_hit && (ldm_r == DTDP_ARMED ||
                    (ldm_r == DTDP_COUNT && !l_ign)); // R11 R13
  wire l_to_cap = !xmit && l_ign && ldm_r == DTDP_COUNT && s_term; // R14
  wire [15:0] l_cap_val = ~lcnt_r;
  wire s_rearm_en = wr_sctl && wdata_i[B_EN] && !s_en;
  wire l_rearm = wr_lctl && wdata_i[B_SM] && !l_ign; // R15
  wire s_to_set = s_term;
  wire l_to_set = l_term || (!xmit && l_zero); // R16
  wire pp_s_end = pingpong && s_term; // R19
  wire pp_l_end = pingpong && l_term; // R19
  wire s_edge = !xmit && s_en && edge_hit;
  wire s_cap = s_edge && (sdm_r == DTDP_COUNT) && !s_rearm_en && !pp_l_end; // R7
  wire l_start = wr_lctl && wdata_i[B_EN] && !l_en;
  wire l_load = pp_s_end || (l_start && xmit);
  wire l_rearm_hit = l_rearm && (ldm_r != DTDP_IDLE);
  wire l_cap_en = (l_edge_cap || l_to_cap) && !l_load && !l_start && !l_rearm_hit;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      pre_r <= 3'h0;
    end else begin
      pre_r <= pre_r + 3'h1;
    end
  end

  // Pin is asynchronous: two stages, then an edge stage
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      {sync1_r, sync2_r, sync3_r} <= 3'h0;
    end else begin
      {sync1_r, sync2_r, sync3_r} <= {demod_in_i, sync1_r, sync2_r};
    end
  end

  // Mode control: edge status set wins over clear-by-write
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      mctl_r <= RST_MODE;
    end else begin
      if (wr_mctl && wdata_i[M_XMIT]) begin
        // Transmit: low bits are initial output levels, not status
        mctl_r <= wdata_i; // R18
      end else if (wr_mctl) begin
        mctl_r <= {wdata_i[7:2], mctl_r[M_EDR] & ~wdata_i[M_EDR],
                   mctl_r[M_EDF] & ~wdata_i[M_EDF]};
      end
      if (l_edge_cap && rise) begin
        mctl_r[M_EDR] <= 1'b1; // R12
      end
      if (l_edge_cap && fall) begin
        mctl_r[M_EDF] <= 1'b1; // R12
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      srl_lo_r <= RST_CTRL;
      srl_hi_r <= RST_CTRL;
      lrl_lo_r <= RST_CTRL;
      lrl_hi_r <= RST_CTRL;
    end else begin
      if (wr_srl_lo) srl_lo_r <= wdata_i;
      if (wr_srl_hi) srl_hi_r <= wdata_i;
      if (wr_lrl_lo) lrl_lo_r <= wdata_i;
      if (wr_lrl_hi) lrl_hi_r <= wdata_i;
    end
  end

  // Short control: timeout set wins over clear-by-write
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      sctl_r <= RST_CTRL;
    end else begin
      if (wr_sctl) begin
        sctl_r <= {wdata_i[7:6], sctl_r[B_TO] & ~wdata_i[B_TO], wdata_i[4:0]};
      end
      if (s_to_set) begin
        sctl_r[B_TO] <= 1'b1;
      end
      if (s_term && (pingpong || sctl_r[B_SM])) begin
        sctl_r[B_EN] <= 1'b0; // R2 R19
      end
      if (pp_l_end) begin
        sctl_r[B_EN] <= 1'b1; // R19
      end
    end
  end

  // Short captures hold the complemented count running since the first selected edge
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      scap_lo_r <= 8'h00;
      scap_hi_r <= 8'h00;
    end else if (s_cap) begin
      if (rise) scap_lo_r <= ~scnt_r; // R7
      if (fall) scap_hi_r <= ~scnt_r; // R7
    end
  end

  // Short counter
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      scnt_r <= 8'h00;
      sout_r <= 1'b0;
      sdm_r <= DTDP_IDLE;
    end else begin
      if (s_rearm_en || pp_l_end) begin
        if (pingpong) begin
          sout_r <= mctl_r[M_INIT_S]; // R18
          scnt_r <= mctl_r[M_INIT_S] ? srl_hi_r : srl_lo_r; // R18
        end else if (xmit) begin
          scnt_r <= s_hold;
        end
        sdm_r <= DTDP_ARMED;
      end else if (s_edge) begin
        if (sdm_r != DTDP_COUNT) begin
          sdm_r <= DTDP_COUNT; // R6
          scnt_r <= srl_lo_r;
        end
      end else if (s_run && s_tick) begin
        if (s_term && xmit && !sctl_r[B_SM] && !pingpong) begin
          sout_r <= s_next_out;
          scnt_r <= s_hold; // R2
        end else if (!(s_term && xmit)) begin
          scnt_r <= scnt_r - 8'h01; // R22
        end else begin
          sout_r <= s_next_out;
        end
      end
    end
  end

  // Long control: timeout set wins over clear-by-write
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      lctl_r <= RST_CTRL;
    end else begin
      if (wr_lctl) begin
        lctl_r <= {wdata_i[7:6], lctl_r[B_TO] & ~wdata_i[B_TO], wdata_i[4:0]}; // R1
      end
      if (l_to_set) begin
        lctl_r[B_TO] <= 1'b1; // R16
      end
      if (l_term && xmit && (pingpong || lctl_r[B_SM])) begin
        lctl_r[B_EN] <= 1'b0; // R2 R19
      end
      if (pp_s_end) begin
        lctl_r[B_EN] <= 1'b1; // R19
      end
    end
  end

  // Long capture pair, written as one 16-bit value
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      lcap_lo_r <= 8'h00;
      lcap_hi_r <= 8'h00;
    end else if (l_cap_en) begin
      {lcap_hi_r, lcap_lo_r} <= l_cap_val; // R10 R11 R14
    end
  end

  // Long counter
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      lcnt_r <= 16'h0000;
      lout_r <= 1'b0;
      ldm_r <= DTDP_IDLE;
    end else begin
      if (l_load) begin
        lout_r <= pingpong ? mctl_r[M_INIT_L] : lout_r; // R19
        lcnt_r <= l_hold;
      end else if (l_start) begin
        ldm_r <= DTDP_ARMED;
      end else if (l_rearm_hit) begin
        ldm_r <= DTDP_ARMED; // R15
      end else if (l_cap_en) begin
        if (l_edge_cap) begin
          lcnt_r <= (ldm_r == DTDP_ARMED) ? l_hold : ALL_ONES16; // R10 R11
          ldm_r <= DTDP_COUNT;
        end
      end else if (l_run && l_tick) begin
        if (l_term && xmit) begin
          lout_r <= ~lout_r;
          if (!lctl_r[B_SM] && !pingpong) lcnt_r <= l_hold; // R2
        end else begin
          lcnt_r <= lcnt_r - 16'h0001; // R8 R16 R22
        end
      end
    end
  end

  // Interrupt lines: one-cycle pulses per event
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      sirq_r <= 1'b0;
    end else begin
      sirq_r <= s_to_set && sctl_r[B_TOIE]; // R20
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      lirq_r <= 1'b0;
    end else begin
      lirq_r <= (l_to_set && lctl_r[B_TOIE]) || (l_cap_en && lctl_r[B_CAPIE]); // R12 R14 R20
    end
  end

  wire [7:0] rd_mux = (addr_i == A_SHORT_CTRL) ? sctl_r :
                      (addr_i == A_MODE_CTRL) ? mctl_r :
                      (addr_i == A_LONG_CTRL) ? lctl_r :
                      (addr_i == A_SRL_LOW) ? srl_lo_r :
                      (addr_i == A_SRL_HIGH) ? srl_hi_r :
                      (addr_i == A_LRL_LOW) ? lrl_lo_r :
                      (addr_i == A_LRL_HIGH) ? lrl_hi_r :
                      (addr_i == A_LCAP_LOW) ? lcap_lo_r :
                      (addr_i == A_LCAP_HIGH) ? lcap_hi_r :
                      (addr_i == A_SCAP_LOW) ? scap_lo_r :
                      (addr_i == A_SCAP_HIGH) ? scap_hi_r : 8'h00;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rd_i ? rd_mux : 8'h00;
    end
  end

  // Pins always drive the timer level; B_OUTEN gates nothing
  assign rdata_o = rdata_r;
  assign short_timer_output_o = sout_r;
  assign long_timer_output_o = lout_r;
  assign short_irq_o = sirq_r;
  assign long_irq_o = lirq_r;
endmodule

// *** dtdp_timer_assertions.sv ***
module dtdp_timer_chk
  import dtdp_pkg::*;
(
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic demod_in_i,
  input wire logic [7:0] rdata_o,
  input wire logic short_timer_output_o,
  input wire logic long_timer_output_o,
  input wire logic short_irq_o,
  input wire logic long_irq_o
);
  logic arm_r;
  logic arm_nxt;
  // Any write that could start a timer, ping-pong included
  assign arm_nxt = arm_r | (wr_i & ((addr_i == A_LONG_CTRL) ? wdata_i[B_EN] : (addr_i < 4'h2)));
  always_ff @(posedge mclk_i) begin
    arm_r <= srst_i ? 1'b0 : arm_nxt;
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  rst_quiet_a: assert property (disable iff (1'b0) $past(srst_i) |->
    {rdata_o, short_irq_o, long_irq_o} == 10'h000) else $error("outputs not quiet after reset");
  rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data without read");
  unmapped_zero_a: assert property (rd_i && (addr_i == 4'h3 || addr_i > A_SCAP_HIGH) |=>
    rdata_o == 8'h00) else $error("unmapped read not zero");
  reload_echo_a: assert property (wr_i && addr_i inside {[A_SRL_LOW:A_LRL_HIGH]} ##1
    rd_i && addr_i == $past(addr_i) |=> rdata_o == $past(wdata_i, 2)) else $error("reload lost");
  ctrl_echo_a: assert property (wr_i && addr_i == A_LONG_CTRL ##1 rd_i && addr_i == A_LONG_CTRL
    |=> rdata_o[4:0] == $past(wdata_i[4:0], 2)) else $error("long control not stored");
  short_pulse_a: assert property (short_irq_o |=> !short_irq_o) else $error("short irq too long");
  long_pulse_a: assert property (long_irq_o |=> !long_irq_o) else $error("long irq too long");
  idle_irq_a: assert property (!arm_r |-> !long_irq_o && !short_irq_o)
    else $error("irq before any timer start");
  cover property (long_irq_o);
  cover property (rd_i && addr_i == A_LCAP_LOW);
  cover property (wr_i && addr_i == A_MODE_CTRL);
endmodule

bind dtdp_timer dtdp_timer_chk dtdp_timer_chk_inst (.mclk_i(mclk_i), .srst_i(srst_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .demod_in_i(demod_in_i),
  .rdata_o(rdata_o), .short_timer_output_o(short_timer_output_o),
  .long_timer_output_o(long_timer_output_o), .short_irq_o(short_irq_o), .long_irq_o(long_irq_o));

// *** dtdp_timer_bench.sv ***
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module dtdp_timer_bench
  import dtdp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i = 1'b0, srst_i = 1'b1, wr_r = 1'b0, rd_r = 1'b0, go_r = 1'b0, rd_q = 1'b0;
  logic [3:0] addr_r = 4'h0;
  logic [7:0] wdata_r = 8'h00, len_r = 8'h00, rdata_o, rv;
  logic short_irq_o, long_irq_o, demod_in_i, s_out, l_out;
  logic [15:0] n_s = 16'h0, n_l = 16'h0, base, e, base2;
  logic [15:0] q[$];
  int n_mismatch = 0, checks = 0, seed = 32'hcb206dfc;
  initial forever #10 mclk_i = ~mclk_i;
  dtdp_timer dtdp_timer_inst (.mclk_i(mclk_i), .srst_i(srst_i), .addr_i(addr_r),
    .wdata_i(wdata_r), .wr_i(wr_r), .rd_i(rd_r), .demod_in_i(demod_in_i), .rdata_o(rdata_o),
    .short_timer_output_o(s_out), .long_timer_output_o(l_out), .short_irq_o(short_irq_o),
    .long_irq_o(long_irq_o));
  dtdp_carrier dtdp_carrier_inst (.mclk_i(mclk_i), .go_i(go_r), .len_i(len_r),
    .carrier_o(demod_in_i));
  task rng(input logic [15:0] g, input logic [15:0] lo, input logic [15:0] hi);
    `CHK(g, (g >= lo && g <= hi) ? g : lo)
  endtask
  // Read data stand only in the cycle after the strobe
  always @(posedge mclk_i) begin
    rd_q <= rd_r;
    n_s <= n_s + {15'h0, short_irq_o};
    n_l <= n_l + {15'h0, long_irq_o};
  end
  always @(negedge mclk_i) if (rd_q) begin
    e = q.pop_front();
    rng({8'h00, rdata_o}, {8'h00, e[15:8]}, {8'h00, e[7:0]});
  end
  task tick(input int n);
    @(posedge mclk_i);
    wr_r <= 1'b0;
    rd_r <= 1'b0;
    repeat (n - 1) @(posedge mclk_i);
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_r <= a;
    wdata_r <= d;
    wr_r <= 1'b1;
    rd_r <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] lo, input logic [7:0] hi);
    @(posedge mclk_i);
    addr_r <= a;
    rd_r <= 1'b1;
    wr_r <= 1'b0;
    q.push_back({lo, hi});
  endtask
  task burst(input logic [7:0] n);
    tick(1);
    len_r <= n;
    go_r <= 1'b1;
    @(posedge mclk_i);
    go_r <= 1'b0;
  endtask
  // Stop first, clear flags three clocks later
  task stop_long;
    wr(A_LONG_CTRL, 8'h02);
    tick(2);
    wr(A_LONG_CTRL, 8'h22);
  endtask
  task conclude;
    if (n_mismatch == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge mclk_i);
    srst_i <= 1'b0;
    rd(A_MODE_CTRL, RST_MODE, RST_MODE);
    rd(A_LONG_CTRL, RST_CTRL, RST_CTRL);
    rd(A_SHORT_CTRL, RST_CTRL, RST_CTRL);
    rd(4'h3, 8'h00, 8'h00);
    rd(4'hc, 8'h00, 8'h00);
    for (int i = 4; i < 8; i++) begin
      rv = 8'($random(seed));
      wr(4'(i), rv);
      rd(4'(i), rv, rv);
    end
    wr(A_LRL_LOW, 8'h05);
    wr(A_LRL_HIGH, 8'h00);
    base = n_l;
    tick(30);
    rng(n_l - base, 16'd0, 16'd0);
    wr(A_LONG_CTRL, 8'h82);
    rd(A_LONG_CTRL, 8'h82, 8'h82);
    base = n_l;
    tick(60);
    rng(n_l - base, 16'd5, 16'd13);
    rd(A_LONG_CTRL, 8'ha2, 8'ha2);
    stop_long();
    rd(A_LONG_CTRL, 8'h02, 8'h02);
    wr(A_LONG_CTRL, 8'hc2);
    base = n_l;
    tick(60);
    rng(n_l - base, 16'd1, 16'd1);
    stop_long();
    wr(A_LONG_CTRL, 8'h9a);
    base = n_l;
    tick(200);
    rng(n_l - base, 16'd4, 16'd6);
    stop_long();
    wr(A_LRL_LOW, 8'h00);
    wr(A_LRL_HIGH, 8'h00);
    wr(A_LONG_CTRL, 8'h82);
    base = n_l;
    tick(100);
    rng(n_l - base, 16'd0, 16'd0);
    stop_long();
    wr(A_SRL_LOW, 8'h00);
    wr(A_SRL_HIGH, 8'h00);
    wr(A_SHORT_CTRL, 8'h82);
    base = n_s;
    tick(100);
    rng(n_s - base, 16'd0, 16'd0);
    wr(A_SHORT_CTRL, 8'h00);
    wr(A_MODE_CTRL, 8'h20);
    wr(A_SRL_LOW, ALL_ONES8);
    wr(A_SRL_HIGH, ALL_ONES8);
    wr(A_SHORT_CTRL, 8'h80);
    tick(4);
    burst(8'd12);
    tick(30);
    rd(A_SCAP_HIGH, 8'd10, 8'd14);
    rd(A_SCAP_LOW, 8'h00, 8'h00);
    wr(A_SHORT_CTRL, 8'h00);
    wr(A_MODE_CTRL, 8'h03);
    wr(A_LRL_LOW, ALL_ONES8);
    wr(A_LRL_HIGH, ALL_ONES8);
    wr(A_LONG_CTRL, 8'h84);
    tick(4);
    base = n_l;
    burst(8'd10);
    tick(38);
    burst(8'd10);
    tick(20);
    rd(A_LCAP_LOW, 8'd38, 8'd42);
    rd(A_LCAP_HIGH, 8'h00, 8'h00);
    rd(A_MODE_CTRL, 8'h02, 8'h03);
    rng(n_l - base, 16'd1, 16'd2);
    stop_long();
    wr(A_SHORT_CTRL, 8'h20);
    wr(A_SRL_LOW, 8'h03);
    wr(A_SRL_HIGH, 8'h03);
    wr(A_LRL_LOW, 8'h04);
    wr(A_LRL_HIGH, 8'h00);
    wr(A_LONG_CTRL, 8'h42);
    wr(A_MODE_CTRL, 8'h86);
    wr(A_SHORT_CTRL, 8'hc2);
    tick(2);
    #1 `CHK(s_out, 1'b1)
    tick(4);
    #1 `CHK(l_out, 1'b0)
    base = n_s;
    base2 = n_l;
    tick(70);
    rng(n_s - base, 16'd8, 16'd12);
    rng(n_l - base2, 16'd8, 16'd12);
    wr(A_MODE_CTRL, 8'h80);
    tick(20);
    base = n_s;
    base2 = n_l;
    tick(40);
    rng(n_s - base, 16'd0, 16'd0);
    rng(n_l - base2, 16'd0, 16'd0);
    tick(3);
    rng(16'(q.size()), 16'd0, 16'd0);
    conclude();
  end
endmodule
